//--- design/lse_defines.vh
`ifndef LSE_DEFINES_VH
`define LSE_DEFINES_VH
// header: break 0x00 + sync 0x55 sit below the identifier byte
`define LSE_BREAK_SYNC 32'h00555000
`define LSE_PID_SHIFT 24
`define LSE_BITS_HEADER 8'h20
`define LSE_BITS_BYTE 8'h08
`define LSE_BITS_BREAK 8'h0D
`define LSE_SHIFTER_W 32
`define LSE_BYTE_W 8
`define LSE_CNT_W 8
`define LSE_DIV_DEFAULT 8'h31
`define LSE_FIFO_DEPTH 16
`endif

//--- design/lse_fifo.v
`timescale 1ns/1ns
module lse_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire ref_clk, // clock
	input wire rst_n, // sync reset, active low
	input wire inValid, // write request
	output wire inReady, // space available
	input wire [WIDTH-1:0] inData, // write data
	output wire outValid, // data available
	input wire outReady, // read accept
	output wire [WIDTH-1:0] outData // head entry
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire doWr = inValid && inReady;
	wire doRd = outValid && outReady;
	assign inReady = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData = mem[rdPtr];
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				mem[wrPtr] <= inData;
				wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wrPtr + 1'b1;
			end
			if (doRd)
				rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rdPtr + 1'b1;
			if (doWr && !doRd)
				count <= count + 1'b1;
			else if (doRd && !doWr)
				count <= count - 1'b1;
		end
	end
endmodule // lse_fifo

//--- design/lse_baud_timer.v
`timescale 1ns/1ns
// dual 8-bit baud timer: low byte divides, high byte counts edges
module lse_baud_timer #(
	parameter CW = 8
) (
	input wire ref_clk, // clock
	input wire rst_n, // sync reset, active low
	input wire run, // timer enabled
	input wire restart, // reload counters
	input wire [CW-1:0] divLoad, // low byte of compare
	input wire [CW-1:0] edgeLoad, // high byte of compare
	output reg tmrOut, // timer output level
	output reg rise, // pulse: output rising
	output reg fall, // pulse: output falling
	output reg done // pulse: compare reached
);
	reg [CW-1:0] divCnt;
	reg [CW-1:0] edgeCnt;
	always @(posedge ref_clk) begin
		rise <= 1'b0;
		fall <= 1'b0;
		done <= 1'b0;
		if (!rst_n || restart || !run) begin
			divCnt <= divLoad;
			edgeCnt <= edgeLoad;
			tmrOut <= 1'b0;
		end else if (divCnt == {CW{1'b0}}) begin
			divCnt <= divLoad;
			tmrOut <= ~tmrOut;
			rise <= ~tmrOut;
			fall <= tmrOut;
			if (edgeCnt == {CW{1'b0}})
				done <= 1'b1;
			else
				edgeCnt <= edgeCnt - 1'b1;
		end else begin
			divCnt <= divCnt - 1'b1;
		end
	end
endmodule // lse_baud_timer

//--- design/lse_lin_node.v
`timescale 1ns/1ns
`include "lse_defines.vh"
// Notes on behaviour
// - tx uses dual 8-bit timer, 32-bit shifter
// - rx uses own baud timer and shifter
// - compare set for 32 or 8 bits
// - header is PID<<24 ORed break/sync
// - shift out with automatic start/stop
// - rx shifter stores on store event
// - store sets rx flag, interrupt capable
// - rx byte read byte-swapped, newest low
// - master header has no start/stop bits
// - slave first waits 13-bit break
// - tx shifts on rising edge, pin 0
// - start bit 0 first, stop 1 at store
// - tx timer triggered by shifter flag low; code runs it while txFull is high
// - timer output 0 when enabled or reset
// - timer decrements each clock, clocks shifter
// - enable on trigger, stop on compare
// - tx timer start bit and stop bit
// - compare high 2n-1, low div/2-1
// - rx samples on falling edge, pin 2
module lse_lin_node #(
	parameter DEPTH = `LSE_FIFO_DEPTH,
	parameter AW = 4,
	parameter [7:0] BAUD_DIV = `LSE_DIV_DEFAULT
) (
	input wire ref_clk, // 100 MHz clock
	input wire rst_n, // sync reset, active low
	input wire masterMode, // 1 master, 0 slave
	input wire sendHeader, // pulse: send break/sync/pid, master mode only
	input wire [7:0] protId, // protected identifier
	input wire txValid, // data byte offered
	input wire [7:0] txByte, // data byte
	output reg txReady, // fifo can take a byte
	input wire rxPin, // serial input, pin 2
	input wire rxReady, // consumer takes rx byte
	output reg rxValid, // rx byte available
	output reg [7:0] rxByte, // received byte
	output reg rxFlag, // sticky: store happened
	input wire rxFlagClr, // clear rxFlag
	output reg breakSeen, // slave saw break field
	output reg txPin, // serial output, pin 0
	output reg txPinOe, // pin 0 drive enable
	output reg baudClk, // tx timer pin 1
	output reg txBusy // frame in progress
);
	wire fifoValid;
	wire [7:0] fifoData;
	reg fifoPop;
	lse_fifo #(.WIDTH(`LSE_BYTE_W), .DEPTH(DEPTH), .AW(AW)) txFifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.inValid(txPush),
		.inReady(),
		.inData(txByte),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);

	// own copy of the fifo fill, so txReady can come from a flop
	reg [AW:0] txFill;
	reg [AW:0] next_txFill;
	wire txPush = txValid && txReady;
	always @* begin
		next_txFill = txFill;
		if (txPush && !fifoPop)
			next_txFill = txFill + 1'b1;
		else if (fifoPop && !txPush)
			next_txFill = txFill - 1'b1;
	end
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			txFill <= {(AW+1){1'b0}};
			txReady <= 1'b1;
		end else begin
			txFill <= next_txFill;
			txReady <= (next_txFill != DEPTH[AW:0]);
		end
	end

	// transmit: shifter flag txFull high means data pending, which runs the timer
	reg [`LSE_SHIFTER_W-1:0] txShift;
	reg [7:0] txBits;
	reg txFull;
	reg txFramed;
	reg txStarted;
	reg txRunD;
	reg [7:0] txEdges;
	wire txRun = txFull;
	wire txRestart = txRun && !txRunD;
	wire txRise;
	wire txDone;
	wire txTmr;
	lse_baud_timer #(.CW(`LSE_CNT_W)) txTimer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(txRun),
		.restart(txRestart),
		.divLoad(BAUD_DIV),
		.edgeLoad(txEdges),
		.tmrOut(txTmr),
		.rise(txRise),
		.fall(),
		.done(txDone)
	);
	always @* begin
		// compare high byte: two edges per bit, plus start/stop when framed
		if (txFramed)
			txEdges = ((txBits + 8'h02) << 1) - 8'h01;
		else
			txEdges = (txBits << 1) - 8'h01;
	end

	// identifier in the top byte, above the break and sync pattern
	wire [`LSE_SHIFTER_W-1:0] hdrWord =
		({24'h000000, protId} << `LSE_PID_SHIFT) | `LSE_BREAK_SYNC;
	wire [`LSE_SHIFTER_W-1:0] byteWord = {24'h000000, fifoData};

	always @(posedge ref_clk) begin
		if (!rst_n)
			txRunD <= 1'b0;
		else
			txRunD <= txRun;
	end

	// pin-side copies, one cycle behind the timer and shifter
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			baudClk <= 1'b0;
			txBusy <= 1'b0;
			txPinOe <= 1'b1;
		end else begin
			baudClk <= txTmr;
			txBusy <= txFull;
			txPinOe <= 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		fifoPop <= 1'b0;
		if (!rst_n) begin
			txShift <= {`LSE_SHIFTER_W{1'b0}};
			txBits <= 8'h00;
			txFull <= 1'b0;
			txFramed <= 1'b0;
			txStarted <= 1'b0;
			txPin <= 1'b1;
		end else begin
			if (!txFull) begin
				txPin <= 1'b1;
				txStarted <= 1'b0;
				if (sendHeader && masterMode) begin
					txShift <= hdrWord;
					txBits <= `LSE_BITS_HEADER;
					txFramed <= 1'b0;
					txFull <= 1'b1;
				end else if (fifoValid && !fifoPop) begin
					txShift <= byteWord;
					txBits <= `LSE_BITS_BYTE;
					txFramed <= 1'b1;
					txFull <= 1'b1;
					fifoPop <= 1'b1;
				end
			end else if (txDone) begin
				txPin <= 1'b1;
				txFull <= 1'b0;
			end else if (txRise) begin
				if (txFramed && !txStarted) begin
					txPin <= 1'b0;
					txStarted <= 1'b1;
				end else if (txFramed && txBits == 8'h00) begin
					txPin <= 1'b1;
				end else begin
					txPin <= txShift[0];
					txShift <= txShift >> 1;
					txBits <= txBits - 8'h01;
				end
			end
		end
	end

	// receive: timer starts on falling line edge (start bit)
	reg rxLineD;
	reg rxRun;
	reg [7:0] rxBitsDone;
	reg [`LSE_SHIFTER_W-1:0] rxShift;
	reg rxWaitBreak;
	reg rxSawHigh;
	reg [7:0] rxEdges;
	wire rxFallPin = rxLineD && !rxPin;
	wire rxFall;
	wire rxDone;
	wire rxTmr;
	wire slaveWait = rxWaitBreak && !masterMode;
	wire rxEnd = rxRun && rxDone;
	wire rxStore = rxEnd && !slaveWait;
	wire rxBreakOk = rxEnd && slaveWait && !rxSawHigh;
	lse_baud_timer #(.CW(`LSE_CNT_W)) rxTimer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(rxRun),
		.restart(rxFallPin && !rxRun),
		.divLoad(BAUD_DIV),
		.edgeLoad(rxEdges),
		.tmrOut(rxTmr),
		.rise(),
		.fall(rxFall),
		.done(rxDone)
	);
	always @* begin
		if (slaveWait)
			rxEdges = (`LSE_BITS_BREAK << 1) - 8'h01;
		else
			rxEdges = ((`LSE_BITS_BYTE + 8'h02) << 1) - 8'h01;
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rxLineD <= 1'b1;
			rxRun <= 1'b0;
			rxBitsDone <= 8'h00;
			rxShift <= {`LSE_SHIFTER_W{1'b0}};
			rxSawHigh <= 1'b0;
		end else begin
			rxLineD <= rxPin;
			if (!rxRun) begin
				rxBitsDone <= 8'h00;
				rxSawHigh <= 1'b0;
				if (rxFallPin)
					rxRun <= 1'b1;
			end else if (rxDone) begin
				rxRun <= 1'b0;
			end else if (rxFall) begin
				rxBitsDone <= rxBitsDone + 8'h01;
				if (rxPin)
					rxSawHigh <= 1'b1;
				// first timer fall already sits in data bit 0
				if (rxBitsDone < `LSE_BITS_BYTE)
					rxShift <= {rxPin, rxShift[31:1]};
			end
		end
	end

	// re-armed while master, so a new slave always hunts a break first
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rxWaitBreak <= 1'b1;
			breakSeen <= 1'b0;
		end else if (masterMode) begin
			rxWaitBreak <= 1'b1;
			breakSeen <= 1'b0;
		end else if (rxBreakOk) begin
			// any high sample voids the break; wait for next low
			rxWaitBreak <= 1'b0;
			breakSeen <= 1'b1;
		end
	end

	// newest byte lands in the low byte, swapped view
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rxValid <= 1'b0;
			rxByte <= 8'h00;
		end else if (rxStore) begin
			rxByte <= rxShift[31:24];
			rxValid <= 1'b1;
		end else if (rxValid && rxReady) begin
			rxValid <= 1'b0;
		end
	end

	// set wins over a clear in the same cycle
	always @(posedge ref_clk) begin
		if (!rst_n)
			rxFlag <= 1'b0;
		else if (rxStore)
			rxFlag <= 1'b1;
		else if (rxFlagClr)
			rxFlag <= 1'b0;
	end
endmodule // lse_lin_node

//--- testbench/lse_lin_partner.sv
`timescale 1ns/1ns
module lse_lin_partner #(
	parameter BIT = 6
) (
	input wire ref_clk, // clock
	output reg linRx // line into node
);
	initial linRx = 1'b1;
	// lsb first; caller ends on a 1 so the line rests recessive
	task sendBits(input [15:0] bits, input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(posedge ref_clk) linRx <= bits[i];
				repeat (BIT - 1) @(posedge ref_clk);
			end
		end
	endtask
endmodule // lse_lin_partner

//--- testbench/lse_lin_node_checker.sv
`timescale 1ns/1ns
module lse_lin_node_checker #(
	parameter [7:0] BAUD_DIV = 8'h31
) (
	input wire ref_clk, // clock
	input wire rst_n, // reset
	input wire masterMode, // mode
	input wire txValid, // tx offer
	input wire txReady, // tx space
	input wire rxReady, // rx take
	input wire rxValid, // rx byte held
	input wire [7:0] rxByte, // rx data
	input wire rxFlag, // rx flag
	input wire rxFlagClr, // flag clear
	input wire breakSeen, // break found
	input wire txPin, // tx line
	input wire txPinOe, // tx drive
	input wire baudClk, // baud out
	input wire txBusy // frame busy
);
	reg [8:0] hiCnt;
	// busy flop, timer load, half bit, rise pulse, then the pin
	localparam int START_LAT = BAUD_DIV + 2;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always @(posedge ref_clk) hiCnt <= baudClk ? hiCnt + 9'h001 : 9'h000;
	chk_oe_on: assert property (txPinOe)
		else $error("tx pin not driven");
	chk_idle_high: assert property (!txBusy |-> txPin)
		else $error("idle line low");
	chk_start_low: assert property ($rose(txBusy)
		|-> ##[0:START_LAT] !txPin)
		else $error("no start bit");
	chk_busy_start: assert property (txValid && txReady && !txBusy
		|-> ##[1:3] txBusy) else $error("timer not triggered");
	chk_baud_half: assert property ($fell(baudClk)
		|-> hiCnt == BAUD_DIV + 9'h001) else $error("baud half wrong");
	chk_flag_set: assert property ($rose(rxValid) |-> rxFlag)
		else $error("flag not set");
	chk_flag_clr: assert property ($fell(rxFlag) |-> $past(rxFlagClr))
		else $error("flag lost");
	chk_rx_hold: assert property (rxValid && !rxReady
		|=> rxValid && $stable(rxByte)) else $error("rx byte dropped");
	chk_break_mst: assert property (masterMode[*2] |-> !breakSeen)
		else $error("break kept in master");
endmodule // lse_lin_node_checker
bind lse_lin_node lse_lin_node_checker #(.BAUD_DIV(BAUD_DIV)) chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .masterMode(masterMode),
	.txValid(txValid), .txReady(txReady), .rxReady(rxReady),
	.rxValid(rxValid), .rxByte(rxByte), .rxFlag(rxFlag),
	.rxFlagClr(rxFlagClr), .breakSeen(breakSeen), .txPin(txPin),
	.txPinOe(txPinOe), .baudClk(baudClk), .txBusy(txBusy));

//--- testbench/lse_lin_node_tb.sv
`timescale 1ns/1ns
module lse_lin_node_tb;
	reg ref_clk, rst_n, masterMode, sendHeader, txValid, rxReady, rxFlagClr;
	reg [7:0] protId, txByte;
	reg [31:0] got;
	wire txReady, rxValid, rxFlag, breakSeen, txPin, txPinOe, baudClk;
	wire txBusy, rxPin;
	wire [7:0] rxByte;
	integer n_fail = 0, checks = 0, cyc = 0;
	lse_lin_node #(.BAUD_DIV(8'h02)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.masterMode(masterMode), .sendHeader(sendHeader), .protId(protId),
		.txValid(txValid), .txByte(txByte), .txReady(txReady), .rxPin(rxPin),
		.rxReady(rxReady), .rxValid(rxValid), .rxByte(rxByte), .rxFlag(rxFlag),
		.rxFlagClr(rxFlagClr), .breakSeen(breakSeen), .txPin(txPin),
		.txPinOe(txPinOe), .baudClk(baudClk), .txBusy(txBusy));
	lse_lin_partner #(.BIT(6)) lin (.ref_clk(ref_clk), .linRx(rxPin));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task summarize;
		begin
			$display("checks %0d fails %0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			summarize;
		end
	end
	task cmp(input [63:0] nm, input [31:0] exp, input [31:0] val);
		begin
			checks = checks + 1;
			if (val !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s exp %h got %h", nm, exp, val);
			end
		end
	endtask
	// sample mid-bit on the falling edge, clear of launch races
	task grab(input integer n);
		integer i;
		begin
			got = 0;
			while (txPin !== 1'b0) @(negedge ref_clk);
			for (i = 0; i < n; i = i + 1) begin
				repeat (i ? 6 : 2) @(negedge ref_clk);
				got[i] = txPin;
			end
		end
	endtask
	// busy dips for one cycle between queued bytes
	task waitIdle;
		integer q;
		begin
			q = 0;
			while (q < 3) begin
				@(negedge ref_clk);
				q = (txBusy === 1'b0) ? q + 1 : 0;
			end
		end
	endtask
	task t_tx;
		begin
			@(posedge ref_clk) txValid <= 1'b1;
			txByte <= 8'hA5;
			@(posedge ref_clk) txByte <= 8'h3C;
			@(posedge ref_clk) txValid <= 1'b0;
			grab(10);
			cmp("byte0", 32'h0000034A, got);
			grab(10);
			cmp("byte1", 32'h00000278, got);
			waitIdle;
			$display("tx done");
		end
	endtask
	task t_hdr;
		begin
			@(posedge ref_clk) sendHeader <= 1'b1;
			protId <= 8'h8B;
			@(posedge ref_clk) sendHeader <= 1'b0;
			grab(32);
			cmp("header", 32'h8B555000, got);
			waitIdle;
			cmp("idle", 1, txPin);
			$display("header done");
		end
	endtask
	task t_full;
		begin
			@(posedge ref_clk) txValid <= 1'b1;
			txByte <= 8'h55;
			repeat (24) @(posedge ref_clk);
			txValid <= 1'b0;
			@(negedge ref_clk) cmp("full", 0, txReady);
			waitIdle;
			cmp("drained", 1, txReady);
			$display("fifo done");
		end
	endtask
	task t_rx;
		begin
			@(posedge ref_clk) masterMode <= 1'b0;
			lin.sendBits(16'h0268, 10);
			repeat (24) @(negedge ref_clk);
			cmp("nobreak", 0, rxValid);
			lin.sendBits(16'h8000, 16);
			@(negedge ref_clk) cmp("break", 1, breakSeen);
			lin.sendBits(16'h02C2, 10);
			repeat (5) @(negedge ref_clk);
			cmp("rxbyte", 8'h61, rxByte);
			cmp("rxflag", 1, rxFlag);
			cmp("rxvalid", 1, rxValid);
			@(posedge ref_clk) rxReady <= 1'b1;
			rxFlagClr <= 1'b1;
			@(posedge ref_clk) rxReady <= 1'b0;
			rxFlagClr <= 1'b0;
			@(negedge ref_clk) cmp("taken", 0, rxValid);
			cmp("clear", 0, rxFlag);
			$display("rx done");
		end
	endtask
	initial begin
		rst_n = 1'b0;
		masterMode = 1'b1;
		sendHeader = 1'b0;
		protId = 8'h00;
		txValid = 1'b0;
		txByte = 8'h00;
		rxReady = 1'b0;
		rxFlagClr = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk) cmp("reset", 1, txPin);
		t_tx;
		t_hdr;
		t_full;
		t_rx;
		summarize;
	end
endmodule // lse_lin_node_tb
